// *** core/qdu_top.sv ***
// serial write port, control decode and channel register update
`timescale 1ns/10ps
`include "qdu_consts.svh"
module qdu_top #(
	parameter int FIFO_DEPTH = `QDU_FIFO_DEPTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe_n,
	input  wire logic [1:0]       addr_pins,
	output qdu_pkg::qdu_chan_t    temp_hold [`QDU_CHANNELS],
	output qdu_pkg::qdu_chan_t    output_code [`QDU_CHANNELS],
	output logic [7:0]            control_byte_store,
	output logic                  frame_active
);
	import qdu_pkg::*;

	localparam int NCH = `QDU_CHANNELS;

	// input synchronisers: stage one feeds stage two only
	logic        scl_s1;
	logic        scl_s2;
	logic        scl_prev;
	logic        sda_s1;
	logic        sda_s2;
	logic        sda_prev;
	logic [1:0]  addr_s1;
	logic [1:0]  addr_s2;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1   <= 1'b1;
			scl_s2   <= 1'b1;
			scl_prev <= 1'b1;
			sda_s1   <= 1'b1;
			sda_s2   <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_s1   <= scl_in;
			scl_s2   <= scl_s1;
			scl_prev <= scl_s2;
			sda_s1   <= sda_in;
			sda_s2   <= sda_s1;
			sda_prev <= sda_s2;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_s1 <= 2'h0;
			addr_s2 <= 2'h0;
		end else begin
			addr_s1 <= addr_pins;
			addr_s2 <= addr_s1;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_rise   = scl_s2 && !scl_prev;
	assign scl_fall   = !scl_s2 && scl_prev;
	// data edges only count as framing while the clock stays high
	assign start_seen = scl_s2 && scl_prev && !sda_s2 && sda_prev;
	assign stop_seen  = scl_s2 && scl_prev && sda_s2 && !sda_prev;

	// ------------------------------------------------------------------
	// byte receiver
	qdu_rx_state_t rx_state;
	logic [7:0]    shift;
	logic [3:0]    bit_cnt;
	logic          is_addr_byte;
	logic          first_data;
	logic          end_pending;
	logic          push_valid;
	qdu_word_t     push_word;
	logic          fifo_in_ready;
	logic          addr_match;

	assign addr_match = !shift[0]
		&& ((shift[7:1] == {`QDU_ADDR_PREFIX, addr_s2})
		|| (shift[7:1] == `QDU_BCAST_ADDR));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state     <= QDU_RX_IDLE;
			shift        <= `QDU_BYTE_RESET;
			bit_cnt      <= 4'h0;
			is_addr_byte <= 1'b0;
			first_data   <= 1'b0;
			sda_oe_n     <= 1'b1;
		end else if (start_seen) begin
			rx_state     <= QDU_RX_ADDR;
			bit_cnt      <= 4'h0;
			is_addr_byte <= 1'b1;
			sda_oe_n     <= 1'b1;
		end else if (stop_seen) begin
			rx_state <= QDU_RX_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			unique case (rx_state)
				QDU_RX_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				QDU_RX_ADDR, QDU_RX_DATA: begin
					if (scl_rise && bit_cnt != `QDU_BITS_PER_BYTE) begin
						shift   <= {shift[6:0], sda_s2};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall
						&& bit_cnt == `QDU_BITS_PER_BYTE) begin
						// no room or wrong address: leave the bus released
						if (fifo_in_ready && !end_pending
							&& (!is_addr_byte || addr_match)) begin
							sda_oe_n <= 1'b0;
							rx_state <= QDU_RX_ACK;
						end else begin
							rx_state <= QDU_RX_IDLE;
						end
					end
				end
				QDU_RX_ACK: begin
					if (scl_fall) begin
						sda_oe_n     <= 1'b1;
						rx_state     <= QDU_RX_DATA;
						bit_cnt      <= 4'h0;
						is_addr_byte <= 1'b0;
						first_data   <= is_addr_byte;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			frame_active <= 1'b0;
		end else if (start_seen) begin
			frame_active <= 1'b1;
		end else if (stop_seen) begin
			frame_active <= 1'b0;
		end
	end

	always_comb begin
		push_valid = 1'b0;
		push_word  = '{kind: QDU_KIND_DATA, data: shift};
		if (end_pending) begin
			push_valid = 1'b1;
			push_word  = '{kind: QDU_KIND_END, data: `QDU_BYTE_RESET};
		end else if (rx_state == QDU_RX_ACK && scl_fall && !is_addr_byte) begin
			push_valid = 1'b1;
			push_word  = '{kind: first_data ? QDU_KIND_CTRL : QDU_KIND_DATA,
				data: shift};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			end_pending <= 1'b0;
		end else if ((start_seen || stop_seen)
			&& rx_state != QDU_RX_IDLE) begin
			end_pending <= 1'b1;
		end else if (fifo_in_ready) begin
			end_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// fifo between link side and decoder
	qdu_word_t pop_word;
	logic      pop_valid;
	logic      pop_ready;

	qdu_fifo #(
		.WIDTH ($bits(qdu_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (push_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_word)
	);

	// ------------------------------------------------------------------
	// decoder
	qdu_dec_state_t dec_state;
	logic [7:0]     upper_data_byte_store;
	logic           pop;

	// commit cycle stalls the drain so the fifo really fills
	assign pop_ready = (dec_state != QDU_DEC_COMMIT);
	assign pop       = pop_valid && pop_ready;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_byte_store <= `QDU_CTRL_RESET;
		end else if (pop && pop_word.kind == QDU_KIND_CTRL) begin
			control_byte_store <= pop_word.data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upper_data_byte_store <= `QDU_BYTE_RESET;
		end else if (pop && dec_state == QDU_DEC_UPPER
			&& pop_word.kind == QDU_KIND_DATA) begin
			upper_data_byte_store <= pop_word.data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dec_state <= QDU_DEC_CTRL;
		end else if (dec_state == QDU_DEC_COMMIT) begin
			dec_state <= QDU_DEC_UPPER;
		end else if (pop) begin
			unique case (pop_word.kind)
				QDU_KIND_END: dec_state <= QDU_DEC_CTRL;
				QDU_KIND_CTRL: dec_state <= QDU_DEC_UPPER;
				QDU_KIND_DATA: begin
					if (dec_state == QDU_DEC_UPPER) begin
						dec_state <= QDU_DEC_LOWER;
					end else if (dec_state == QDU_DEC_LOWER) begin
						dec_state <= QDU_DEC_COMMIT;
					end
				end
				default: dec_state <= QDU_DEC_CTRL;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// control field decode
	logic [1:0] update_mode;
	logic       update_mode_high_bit;
	logic       update_mode_low_bit;
	logic       channel_pick_high;
	logic       channel_pick_low;
	logic       powerdown_request_flag;
	logic [1:0] powerdown_code_bit;
	logic [1:0] pick;

	assign update_mode_high_bit   = control_byte_store[`QDU_MODE_HI];
	assign update_mode_low_bit    = control_byte_store[`QDU_MODE_LO];
	assign update_mode = {update_mode_high_bit, update_mode_low_bit};
	assign channel_pick_high      = control_byte_store[`QDU_PICK_HI];
	assign channel_pick_low       = control_byte_store[`QDU_PICK_LO];
	assign powerdown_request_flag = control_byte_store[`QDU_PD_FLAG];
	assign powerdown_code_bit =
		upper_data_byte_store[`QDU_PD_CODE_HI:`QDU_PD_CODE_LO];
	assign pick = {channel_pick_high, channel_pick_low};

	// value written into a channel; power-down keeps the held code
	function automatic qdu_chan_t new_value(input qdu_chan_t held);
		qdu_chan_t v;
		v = held;
		if (powerdown_request_flag) begin
			v.pd_code = powerdown_code_bit;
		end else begin
			v.pd_code = 2'h0;
			v.code    = upper_data_byte_store;
		end
		return v;
	endfunction : new_value

	// ------------------------------------------------------------------
	// channel registers
	qdu_chan_t next_temp [NCH];
	qdu_chan_t next_out  [NCH];
	logic      commit;

	assign commit = (dec_state == QDU_DEC_COMMIT);

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			next_temp[i] = temp_hold[i];
			next_out[i]  = output_code[i];
			unique case (update_mode)
				`QDU_MODE_TEMP: begin
					if (pick == 2'(i)) begin
						next_temp[i] = new_value(temp_hold[i]);
					end
				end
				`QDU_MODE_DIRECT: begin
					if (pick == 2'(i)) begin
						next_temp[i] = new_value(temp_hold[i]);
						next_out[i]  = new_value(temp_hold[i]);
					end
				end
				`QDU_MODE_ALL: begin
					if (pick == 2'(i)) begin
						next_temp[i] = new_value(temp_hold[i]);
						next_out[i]  = new_value(temp_hold[i]);
					end else begin
						next_out[i] = temp_hold[i];
					end
				end
				`QDU_MODE_BCAST: begin
					if (!channel_pick_high) begin
						next_out[i] = temp_hold[i];
					end else begin
						next_temp[i] = new_value(temp_hold[i]);
						next_out[i]  = new_value(temp_hold[i]);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				temp_hold[i]   <= `QDU_REG_RESET;
				output_code[i] <= `QDU_REG_RESET;
			end
		end else if (commit) begin
			for (int i = 0; i < NCH; i++) begin
				temp_hold[i]   <= next_temp[i];
				output_code[i] <= next_out[i];
			end
		end
	end

endmodule : qdu_top

// *** core/qdu_consts.svh ***
// constants for the quad converter update control block
`ifndef QDU_CONSTS_SVH
`define QDU_CONSTS_SVH

`define QDU_ADDR_PREFIX   5'h13
`define QDU_BCAST_ADDR    7'h48
`define QDU_MODE_HI       5
`define QDU_MODE_LO       4
`define QDU_PICK_HI       2
`define QDU_PICK_LO       1
`define QDU_PD_FLAG       0
`define QDU_PD_CODE_HI    7
`define QDU_PD_CODE_LO    6
`define QDU_MODE_TEMP     2'h0
`define QDU_MODE_DIRECT   2'h1
`define QDU_MODE_ALL      2'h2
`define QDU_MODE_BCAST    2'h3
`define QDU_BITS_PER_BYTE 4'h8
`define QDU_FIFO_DEPTH    16
`define QDU_CHANNELS      4
`define QDU_CTRL_RESET    8'h00
`define QDU_BYTE_RESET    8'h00
`define QDU_REG_RESET     10'h000

`endif

// *** core/qdu_pkg.sv ***
// types shared by the update control block
package qdu_pkg;

	typedef struct packed {
		logic [1:0] pd_code;
		logic [7:0] code;
	} qdu_chan_t;

	typedef enum logic [1:0] {
		QDU_KIND_CTRL = 2'h1,
		QDU_KIND_DATA = 2'h2,
		QDU_KIND_END  = 2'h3
	} qdu_kind_t;

	typedef struct packed {
		qdu_kind_t  kind;
		logic [7:0] data;
	} qdu_word_t;

	typedef enum logic [3:0] {
		QDU_RX_IDLE = 4'h1,
		QDU_RX_ADDR = 4'h2,
		QDU_RX_DATA = 4'h4,
		QDU_RX_ACK  = 4'h8
	} qdu_rx_state_t;

	typedef enum logic [3:0] {
		QDU_DEC_CTRL   = 4'h1,
		QDU_DEC_UPPER  = 4'h2,
		QDU_DEC_LOWER  = 4'h4,
		QDU_DEC_COMMIT = 4'h8
	} qdu_dec_state_t;

endpackage : qdu_pkg

// *** core/qdu_fifo.sv ***
// byte fifo between the serial receiver and the decoder
`timescale 1ns/10ps
module qdu_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule : qdu_fifo

// *** test/qdu_top_chk.sv ***
// port checker for the update control block
`timescale 1ns/10ps
`include "qdu_consts.svh"
module qdu_top_chk #(
	parameter int FIFO_DEPTH = `QDU_FIFO_DEPTH
) (
	input wire logic          clk_sys,
	input wire logic          rst_n,
	input wire logic          sda_oe_n,
	input qdu_pkg::qdu_chan_t temp_hold [`QDU_CHANNELS],
	input qdu_pkg::qdu_chan_t output_code [`QDU_CHANNELS],
	input wire logic [7:0]    control_byte_store,
	input wire logic          frame_active
);
	import qdu_pkg::*;
	logic [39:0] out_flat;
	logic [39:0] temp_flat;
	qdu_chan_t   temp_prev [`QDU_CHANNELS];
	logic [3:0]  tchg;
	logic [3:0]  since_ack;
	logic [1:0]  mode;
	logic [1:0]  sel;

	assign out_flat  = {output_code[0], output_code[1], output_code[2],
		output_code[3]};
	assign temp_flat = {temp_hold[0], temp_hold[1], temp_hold[2],
		temp_hold[3]};
	assign mode = control_byte_store[5:4];
	assign sel  = control_byte_store[2:1];

	// cycles since the acknowledge was last driven, saturating
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			since_ack <= 4'hf;
		else if (!sda_oe_n)
			since_ack <= 4'h0;
		else if (since_ack != 4'hf)
			since_ack <= since_ack + 4'h1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			temp_prev <= '{default: '0};
		else
			temp_prev <= temp_hold;
	end

	always_comb begin
		for (int i = 0; i < 4; i++)
			tchg[i] = temp_hold[i] != temp_prev[i];
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_RESET_CLEAR: assert property (disable iff (1'b0)
		!rst_n |-> out_flat == '0 && temp_flat == '0 && sda_oe_n)
		else $error("registers not cleared in reset");
	AST_OUT_AFTER_ACK: assert property (
		$changed(out_flat) |-> since_ack >= 4'h1 && since_ack <= 4'hc)
		else $error("output update not tied to an acknowledge");
	AST_TEMP_AFTER_ACK: assert property (
		tchg != 4'h0 |-> since_ack >= 4'h1 && since_ack <= 4'hc)
		else $error("temp update not tied to an acknowledge");
	AST_MODE_TEMP_HOLD: assert property (
		$changed(out_flat) |-> mode != `QDU_MODE_TEMP)
		else $error("output changed in temp-only mode");
	AST_DIRECT_LOAD: assert property (
		$changed(out_flat) && mode == `QDU_MODE_DIRECT
		|-> output_code[sel] == temp_hold[sel])
		else $error("direct mode output differs from temp");
	AST_ALL_LOAD: assert property (
		$changed(out_flat) && mode == `QDU_MODE_ALL |-> out_flat == temp_flat)
		else $error("load-all mode output differs from temps");
	AST_BCAST_STORED: assert property (
		$changed(out_flat) && mode == `QDU_MODE_BCAST && !sel[1]
		|-> out_flat == temp_flat && $stable(temp_flat))
		else $error("broadcast update not from temps");
	AST_BCAST_DATA: assert property (
		$changed(out_flat) && mode == `QDU_MODE_BCAST && sel[1]
		&& !control_byte_store[0] |-> output_code[0] == output_code[1]
		&& output_code[1] == output_code[2] && output_code[2] == output_code[3])
		else $error("broadcast data differs across channels");
	AST_BCAST_PD: assert property (
		$changed(out_flat) && mode == `QDU_MODE_BCAST && sel[1]
		&& control_byte_store[0]
		|-> output_code[0].pd_code == output_code[1].pd_code
		&& output_code[1].pd_code == output_code[2].pd_code
		&& output_code[2].pd_code == output_code[3].pd_code)
		else $error("broadcast power-down code differs");
	AST_ONE_CHANNEL: assert property (
		mode != `QDU_MODE_BCAST |-> (tchg & ~(4'h1 << sel)) == 4'h0)
		else $error("temp of an unselected channel changed");
	AST_DATA_CLEARS_PD: assert property (
		mode != `QDU_MODE_BCAST && !control_byte_store[0] && tchg[sel]
		|-> temp_hold[sel].pd_code == 2'h0)
		else $error("data write left a power-down code");
	AST_PD_KEEPS_DATA: assert property (
		mode != `QDU_MODE_BCAST && control_byte_store[0] && tchg[sel]
		|-> temp_hold[sel].code == temp_prev[sel].code)
		else $error("power-down write altered data bits");

	COV_DIRECT: cover property ($changed(out_flat) && mode == 2'h1);
	COV_BCAST: cover property ($changed(out_flat) && mode == 2'h3);
	COV_ACK: cover property (!sda_oe_n && frame_active);
endmodule : qdu_top_chk

bind qdu_top qdu_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .sda_oe_n(sda_oe_n),
	.temp_hold(temp_hold), .output_code(output_code),
	.control_byte_store(control_byte_store), .frame_active(frame_active));

// *** test/qdu_bus_master.sv ***
// two-wire bus master model driving the serial write port
`timescale 1ns/10ps
module qdu_bus_master (
	output logic     scl,
	output logic     sda_pull,
	input wire logic sda_line
);
	// quarter of a 125 ns bit, unrelated to the system clock
	localparam realtime Q = 31.25;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic start_cond();
		sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
	endtask : start_cond

	// clock parks high and the line is released between frames
	task automatic stop_cond();
		#Q sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#(2 * Q);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#Q sda_pull = ~b[i];
			#Q scl = 1'b1;
			#(2 * Q) scl = 1'b0;
		end
		#Q sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q ack = ~sda_line;
		#Q scl = 1'b0;
	endtask : send_byte
endmodule : qdu_bus_master

// *** test/test_qdu_top.sv ***
// randomised bench for the update control block
`timescale 1ns/10ps
`include "qdu_consts.svh"
module test_qdu_top;
	import qdu_pkg::*;
	logic       clk_sys;
	logic       rst_n;
	logic [1:0] addr_pins;
	wire        scl_in;
	wire        sda_in;
	wire        sda_pull;
	logic       sda_out;
	logic       sda_oe_n;
	logic       frame_active;
	logic [7:0] control_byte_store;
	qdu_chan_t  temp_hold [`QDU_CHANNELS];
	qdu_chan_t  output_code [`QDU_CHANNELS];
	logic [9:0] m_temp [4];
	logic [9:0] m_out [4];
	logic       ack;
	int         errors;
	int         checks_done;
	int         seed = 73967;

	// pulled-up line, low when either party pulls
	assign sda_in = ~(sda_pull | ~sda_oe_n);

	qdu_top #(.FIFO_DEPTH(16)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .addr_pins(addr_pins), .temp_hold(temp_hold),
		.output_code(output_code), .control_byte_store(control_byte_store),
		.frame_active(frame_active));
	qdu_bus_master u_master (.scl(scl_in), .sda_pull(sda_pull),
		.sda_line(sda_in));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_all();
		for (int i = 0; i < 4; i++) begin
			check(output_code[i], m_out[i]);
			check(temp_hold[i], m_temp[i]);
		end
	endtask : check_all

	// power-down keeps data bits, data clears the code
	function automatic logic [9:0] nv(input logic [7:0] c,
		input logic [7:0] u, input logic [9:0] old);
		return c[0] ? {u[7:6], old[7:0]} : {2'h0, u};
	endfunction : nv

	task automatic apply(input logic [7:0] c, input logic [7:0] u);
		int s;
		s = int'(c[2:1]);
		if (c[5:4] == 2'h3) begin
			for (int i = 0; i < 4; i++) begin
				// broadcast data or code lands in temp and output alike
				if (c[2]) begin
					m_temp[i] = nv(c, u, m_temp[i]);
				end
				m_out[i] = m_temp[i];
			end
		end else begin
			m_temp[s] = nv(c, u, m_temp[s]);
			if (c[5:4] == 2'h1) begin
				m_out[s] = m_temp[s];
			end
			if (c[5:4] == 2'h2) begin
				m_out = m_temp;
			end
		end
	endtask : apply

	task automatic send(input logic [7:0] b, input logic exp);
		u_master.send_byte(b, ack);
		check({9'h0, ack}, {9'h0, exp});
	endtask : send

	task automatic pair(input logic [7:0] c);
		logic [7:0] u;
		u = 8'($random(seed));
		// code byte keeps bit five clear
		if (c[0]) u[5] = 1'b0;
		send(u, 1'b1);
		repeat (12) @(negedge clk_sys);
		check_all();
		send(8'($random(seed)), 1'b1);
		repeat (12) @(negedge clk_sys);
		apply(c, u);
		check_all();
	endtask : pair

	task automatic frame(input logic [7:0] a, input logic [7:0] c);
		logic hit;
		hit = a == {`QDU_ADDR_PREFIX, addr_pins, 1'b0}
			|| a == {`QDU_BCAST_ADDR, 1'b0};
		u_master.start_cond();
		check({8'h0, frame_active, sda_out}, 10'h002);
		send(a, hit);
		if (hit) begin
			send(c, 1'b1);
			repeat (2) pair(c);
		end
		u_master.stop_cond();
		check({8'h0, frame_active, sda_out}, 10'h000);
		if (hit) check({2'h0, control_byte_store}, {2'h0, c});
	endtask : frame

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	initial begin
		repeat (60000) @(posedge clk_sys);
		errors++;
		final_report();
	end

	initial begin
		logic [7:0] r;
		logic [7:0] c;
		logic [7:0] kb;
		logic [7:0] own;
		rst_n = 1'b1;
		addr_pins = 2'($random(seed));
		m_temp = '{default: '0};
		m_out = '{default: '0};
		errors = 0;
		checks_done = 0;
		own = {`QDU_ADDR_PREFIX, addr_pins, 1'b0};
		// a clean falling reset edge once every process is waiting
		@(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		check_all();
		for (int k = 0; k < 44; k++) begin
			kb = 8'(k);
			r = 8'($random(seed));
			if (k < 24)
				c = {2'h0, kb[4:3], r[3], kb[1:0], kb[2]};
			else if (k < 28)
				c = {r[7:6], 2'h3, r[3], kb[1], r[1], kb[0]};
			else
				c = {2'h0, r[5:0]};
			frame((k > 23 && !kb[0]) ? {`QDU_BCAST_ADDR, 1'b0} : own, c);
		end
		// mid-run reset with the bus idle
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		m_temp = '{default: '0};
		m_out = '{default: '0};
		repeat (4) @(negedge clk_sys);
		check_all();
		check({2'h0, control_byte_store}, 10'h000);
		u_master.start_cond();
		send(own, 1'b1);
		send(8'h12, 1'b1);
		send(8'h5a, 1'b1);
		u_master.stop_cond();
		repeat (12) @(negedge clk_sys);
		check_all();
		frame({`QDU_ADDR_PREFIX, ~addr_pins, 1'b0}, 8'h10);
		frame({`QDU_ADDR_PREFIX, addr_pins, 1'b1}, 8'h10);
		check_all();
		final_report();
	end
endmodule : test_qdu_top
